// ---- core/ridethrough_ctrl.sv ----
// Momentary power loss supervisor with ride-through and restart.
// Assumes a Wishbone classic master, a DC bus reading in volts on clk_i,
// and a speed search engine that answers search_start_o with search_done_i.
`timescale 1ns/10ps
`include "plr_consts.svh"
module ridethrough_ctrl import plr_pkg::*; #(
  parameter int unsigned TICK_CYC = `PLR_TICK_CYC,
  parameter int unsigned LOSS_CYC = `PLR_LOSS_CYC,
  parameter bit HV_CLASS = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic run_cmd_i,
  input wire logic ctrl_supply_ok_i,
  input wire logic [15:0] dc_bus_v_i,
  input wire logic err_i,
  input wire logic search_done_i,
  output logic running_o,
  output logic block_o,
  output logic recovering_o,
  output logic uv_fault_o,
  output logic err_o,
  output logic search_start_o,
  output logic [1:0] search_method_o,
  output logic [7:0] volt_level_o
);

  ////////////////////////////////////////////////////////////////////////
  // Constants and helpers

  localparam logic [15:0] UVL_LO = `PLR_UVL_MIN << HV_CLASS;
  localparam logic [15:0] UVL_HI = `PLR_UVL_MAX << HV_CLASS;
  localparam logic [15:0] UVL_DF = `PLR_UVL_DEF << HV_CLASS;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic in_recovery(input state_e st);
    in_recovery = (st == ST_LOSS) || (st == ST_BLOCK) ||
                  (st == ST_SEARCH) || (st == ST_RAMP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and submodules

  ctrl_s s;
  ctrl_s n;
  logic tick;
  logic tclr;
  logic uv;
  logic acc;
  logic fclr;
  logic wr;
  ramp_if rp ();

  tenth_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(tclr),
    .tick_o(tick)
  );

  volt_ramp #(
    .TICK_CYC(TICK_CYC)
  ) u_ramp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .r(rp.rmp)
  );

  assign uv = dc_bus_v_i < s.auvl;
  assign acc = cyc_i && stb_i && !s.ack;
  // Writes land at the edge where the master sees ack high
  assign wr = cyc_i && stb_i && we_i && s.ack;
  assign fclr = wr && sel_i[0] && (adr_i[15:2] == `PLR_IDX_CTRL) &&
                dat_i[`PLR_CTRL_FCLR];
  // Tick period restarts on every state change
  assign tclr = (n.st != s.st);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.run_m = run_cmd_i;
    n.run_s = s.run_m;
    n.sup_m = ctrl_supply_ok_i;
    n.sup_s = s.sup_m;
    n.ack = acc;
    n.srch = 1'b0;
    n.rstart = 1'b0;

    // Register writes, clamped to the legal ranges
    if (wr) begin
      case (adr_i[15:2])
        `PLR_IDX_MODE: begin
          n.mode = clamp(merge(s.mode, dat_i, sel_i), `PLR_MODE_OFF, `PLR_MODE_MAX);
        end
        `PLR_IDX_RT: begin
          n.rt = clamp(merge(s.rt, dat_i, sel_i), 16'h0000, `PLR_RT_MAX);
        end
        `PLR_IDX_MB: begin
          n.mb = clamp(merge(s.mb, dat_i, sel_i), `PLR_MB_MIN, `PLR_MB_MAX);
        end
        `PLR_IDX_VR: begin
          n.vr = clamp(merge(s.vr, dat_i, sel_i), 16'h0000, `PLR_VR_MAX);
        end
        `PLR_IDX_UVL: begin
          n.uvl = clamp(merge(s.uvl, dat_i, sel_i), UVL_LO, UVL_HI);
        end
        `PLR_IDX_SS: begin
          n.ss = clamp(merge(s.ss, dat_i, sel_i), 16'h0000, `PLR_SS_MAX);
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped words read zero
    if (acc && !we_i) begin
      case (adr_i[15:2])
        `PLR_IDX_MODE: n.rdat = {16'h0000, s.mode};
        `PLR_IDX_RT: n.rdat = {16'h0000, s.rt};
        `PLR_IDX_MB: n.rdat = {16'h0000, s.mb};
        `PLR_IDX_VR: n.rdat = {16'h0000, s.vr};
        `PLR_IDX_UVL: n.rdat = {16'h0000, s.uvl};
        `PLR_IDX_SS: n.rdat = {16'h0000, s.ss};
        `PLR_IDX_STAT: begin
          n.rdat = {25'h0000000, block_o, running_o, in_recovery(s.st), s.fault, s.st};
        end
        default: n.rdat = 32'h00000000;
      endcase
    end

    // Working copy follows the settings only while stopped or faulted
    if (s.st == ST_STOP || s.st == ST_FAULT) begin
      n.amode = s.mode;
      n.art = s.rt;
      n.amb = s.mb;
      n.avr = s.vr;
      n.auvl = s.uvl;
      n.ass = s.ss;
    end

    case (s.st)
      ST_STOP: begin
        if (s.run_s && !uv) begin
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!s.run_s) begin
          n.st = ST_STOP;
        end else if (uv) begin
          n.st = ST_LOSS;
        end
      end
      ST_LOSS: begin
        if (s.amode == `PLR_MODE_OFF) begin
          if (!uv) begin
            n.st = ST_RUN;
          end else if (s.cnt >= 32'(LOSS_CYC - 1)) begin
            n.st = ST_FAULT;
            n.fault = 1'b1;
          end else begin
            n.cnt = s.cnt + 32'h1;
          end
        end else if (s.amode == `PLR_MODE_TIMED) begin
          if (!uv) begin
            n.st = s.run_s ? ST_BLOCK : ST_STOP;
          end else if (s.art == 16'h0000 || (tick && s.cnt + 32'h1 >= 32'(s.art))) begin
            n.st = ST_FAULT;
            n.fault = 1'b1;
          end else if (tick) begin
            n.cnt = s.cnt + 32'h1;
          end
        end else begin
          if (!s.sup_s) begin
            n.st = ST_STOP;
          end else if (!uv) begin
            n.st = s.run_s ? ST_BLOCK : ST_STOP;
          end
        end
      end
      ST_BLOCK: begin
        if (uv) begin
          n.st = ST_LOSS;
        end else if (!s.run_s) begin
          n.st = ST_STOP;
        end else if (tick) begin
          if (s.cnt + 32'h1 >= 32'(s.amb)) begin
            n.st = ST_SEARCH;
            n.srch = 1'b1;
          end else begin
            n.cnt = s.cnt + 32'h1;
          end
        end
      end
      ST_SEARCH: begin
        if (uv) begin
          n.st = ST_LOSS;
        end else if (search_done_i) begin
          n.st = ST_RAMP;
          n.rstart = 1'b1;
        end
      end
      ST_RAMP: begin
        if (uv) begin
          n.st = ST_LOSS;
        end else if (rp.done) begin
          n.st = ST_RUN;
        end
      end
      ST_FAULT: begin
        if (fclr && !s.run_s) begin
          n.st = ST_STOP;
          n.fault = 1'b0;
        end
      end
      default: begin
        n.st = ST_STOP;
      end
    endcase

    if (n.st != s.st) begin
      n.cnt = '0;
    end
    n.err = err_i && !in_recovery(n.st);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{st: ST_STOP, run_m: 1'b0, run_s: 1'b0, sup_m: 1'b0, sup_s: 1'b0,
             cnt: '0, mode: `PLR_MODE_OFF, rt: `PLR_RT_DEF, mb: `PLR_MB_DEF,
             vr: `PLR_VR_DEF, uvl: UVL_DF, ss: `PLR_SS_DEF,
             amode: `PLR_MODE_OFF, art: `PLR_RT_DEF, amb: `PLR_MB_DEF,
             avr: `PLR_VR_DEF, auvl: UVL_DF, ass: `PLR_SS_DEF,
             fault: 1'b0, err: 1'b0, srch: 1'b0, rstart: 1'b0, ack: 1'b0,
             rdat: '0};
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rp.start = s.rstart;
  assign rp.time_t = s.avr[7:0];
  assign dat_o = s.rdat;
  assign ack_o = s.ack;
  assign running_o = (s.st == ST_RUN);
  assign block_o = (s.st != ST_RUN) && (s.st != ST_RAMP);
  assign recovering_o = in_recovery(s.st);
  assign uv_fault_o = s.fault;
  assign err_o = s.err;
  assign search_start_o = s.srch;
  assign search_method_o = s.ass[1:0];
  assign volt_level_o = rp.level;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  loss15_fault_a: assert property (
    (s.st == ST_LOSS && s.amode == `PLR_MODE_OFF && uv && s.cnt >= 32'(LOSS_CYC - 1))
    |=> (s.st == ST_FAULT && uv_fault_o)
  ) else $error("mode 0 loss past 15 ms did not fault");

  timed_restart_a: assert property (
    (s.st == ST_LOSS && s.amode == `PLR_MODE_TIMED && !uv && s.run_s)
    |=> (s.st == ST_BLOCK && block_o && !uv_fault_o)
  ) else $error("mode 1 return did not restart");

  timed_fault_a: assert property (
    (s.st == ST_LOSS && s.amode == `PLR_MODE_TIMED && uv && tick && s.cnt + 32'h1 >= 32'(s.art))
    |=> (s.st == ST_FAULT) ##1 (s.st != ST_BLOCK)
  ) else $error("mode 1 overlong loss did not fault");

  keep_no_uv_a: assert property (
    (s.amode == `PLR_MODE_MAX && s.st != ST_FAULT) |=> !$rose(uv_fault_o)
  ) else $error("mode 2 raised undervoltage");

  rt_range_a: assert property (
    s.rt <= `PLR_RT_MAX && s.art <= `PLR_RT_MAX
  ) else $error("ride-through time out of range");

  min_block_a: assert property (
    (s.st == ST_SEARCH && $past(s.st) == ST_BLOCK)
    |-> ($past(s.cnt) + 32'h1 >= 32'(s.amb) && $past(tick) && search_start_o)
  ) else $error("search started before minimum block time");

  ramp_zero_a: assert property (
    (rp.start && !uv) |=> (rp.level == 8'h00 || s.avr == 16'h0000) && s.st == ST_RAMP
  ) else $error("voltage ramp did not start from zero");

  uv_detect_a: assert property (
    (s.st == ST_RUN && s.run_s && dc_bus_v_i < s.auvl) |=> s.st == ST_LOSS
  ) else $error("undervoltage not detected");

  err_quiet_a: assert property (
    recovering_o |-> !err_o
  ) else $error("error output during recovery");

  search_path_a: assert property (
    (s.st == ST_SEARCH && search_done_i && !uv) |=> (s.st == ST_RAMP && rp.start)
  ) else $error("restart bypassed speed search");

  cfg_hold_a: assert property (
    (s.st != ST_STOP && s.st != ST_FAULT) |=> $stable(s.amode) && $stable(s.auvl)
  ) else $error("settings changed while running");

endmodule

// ---- core/tenth_tick.sv ----
// Divider giving a one-cycle pulse every tenth of a second.
// Assumes clr_i restarts the period so a wait counts whole tenths.
`timescale 1ns/10ps
`include "plr_consts.svh"
module tenth_tick import plr_pkg::*; #(
  parameter int unsigned CYC = `PLR_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  output logic tick_o
);

  tick_s s;
  tick_s n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (clr_i) begin
      n.cnt = '0;
    end else if (s.cnt >= 32'(CYC - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_o = s.tick;

endmodule

// ---- core/volt_ramp.sv ----
// Output voltage ramp from zero to full over a time in tenths.
// Assumes start is a one-cycle pulse; level stays full when idle.
`timescale 1ns/10ps
`include "plr_consts.svh"
module volt_ramp import plr_pkg::*; #(
  parameter int unsigned TICK_CYC = `PLR_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ramp_if.rmp r
);

  ramp_s s;
  ramp_s n;
  logic [31:0] step_len;

  // Cycles per level step: whole ramp spans time_t tenths
  assign step_len = 32'(r.time_t) * 32'(TICK_CYC / `PLR_RAMP_STEPS);

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (r.start) begin
      n.busy = 1'b1;
      n.cnt = '0;
      n.level = (r.time_t == 8'h00) ? `PLR_LEVEL_MAX : 8'h00;
    end else if (s.busy) begin
      if (s.level == `PLR_LEVEL_MAX) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else if (s.cnt + 32'h1 >= step_len) begin
        n.cnt = '0;
        n.level = s.level + 8'h01;
      end else begin
        n.cnt = s.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{busy: 1'b0, done: 1'b0, cnt: '0, level: `PLR_LEVEL_MAX};
    end else begin
      s <= n;
    end
  end

  assign r.done = s.done;
  assign r.level = s.level;

endmodule

// ---- include/plr_consts.svh ----
// Constants of the power loss ride-through block.
// Assumes a 200 MHz controller clock and word-aligned Wishbone registers.
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH
`define PLR_CLK_MHZ 200
`define PLR_TICK_MS 100
`define PLR_LOSS_MS 15
`define PLR_TICK_CYC (`PLR_TICK_MS * 1000 * `PLR_CLK_MHZ)
`define PLR_LOSS_CYC (`PLR_LOSS_MS * 1000 * `PLR_CLK_MHZ)
`define PLR_IDX_MODE 14'h485
`define PLR_IDX_RT 14'h486
`define PLR_IDX_MB 14'h487
`define PLR_IDX_VR 14'h488
`define PLR_IDX_UVL 14'h489
`define PLR_IDX_CTRL 14'h48A
`define PLR_IDX_STAT 14'h48B
`define PLR_IDX_SS 14'h191
`define PLR_MODE_OFF 16'h0000
`define PLR_MODE_TIMED 16'h0001
`define PLR_MODE_MAX 16'h0002
`define PLR_RT_DEF 16'h0001
`define PLR_RT_MAX 16'h00FF
`define PLR_MB_MIN 16'h0001
`define PLR_MB_MAX 16'h0032
`define PLR_MB_DEF 16'h0002
`define PLR_VR_MAX 16'h0032
`define PLR_VR_DEF 16'h0003
`define PLR_UVL_MIN 16'h0096
`define PLR_UVL_MAX 16'h00D2
`define PLR_UVL_DEF 16'h00BE
`define PLR_SS_MAX 16'h0003
`define PLR_SS_DEF 16'h0002
`define PLR_CTRL_FCLR 0
`define PLR_LEVEL_MAX 8'hFF
`define PLR_RAMP_STEPS 256
`endif

// ---- include/plr_pkg.sv ----
// Types of the power loss ride-through block.
// Assumes nothing beyond the tool's SystemVerilog support.
package plr_pkg;

  // Gray along stop, run, loss, block, search, ramp
  typedef enum logic [2:0] {
    ST_STOP = 3'h0,
    ST_RUN = 3'h1,
    ST_LOSS = 3'h3,
    ST_BLOCK = 3'h2,
    ST_SEARCH = 3'h6,
    ST_RAMP = 3'h7,
    ST_FAULT = 3'h5
  } state_e;

  typedef struct packed {
    state_e st;
    logic run_m;
    logic run_s;
    logic sup_m;
    logic sup_s;
    logic [31:0] cnt;
    logic [15:0] mode;
    logic [15:0] rt;
    logic [15:0] mb;
    logic [15:0] vr;
    logic [15:0] uvl;
    logic [15:0] ss;
    logic [15:0] amode;
    logic [15:0] art;
    logic [15:0] amb;
    logic [15:0] avr;
    logic [15:0] auvl;
    logic [15:0] ass;
    logic fault;
    logic err;
    logic srch;
    logic rstart;
    logic ack;
    logic [31:0] rdat;
  } ctrl_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] cnt;
    logic [7:0] level;
  } ramp_s;

endpackage

// ---- include/ramp_if.sv ----
// Link between the sequencer and the output voltage ramp.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ramp_if;
  logic start;
  logic [7:0] time_t;
  logic done;
  logic [7:0] level;
  modport ctl (output start, output time_t, input done, input level);
  modport rmp (input start, input time_t, output done, output level);
endinterface

// ---- test/plr_partner.sv ----
// Far-side model: main power stage, run command source and search engine.
// Assumes the bench sets power, control supply, run request and search delay.
`timescale 1ns/10ps
module plr_partner (
  input wire logic clk_i,
  input wire logic pwr_i,
  input wire logic sup_i,
  input wire logic run_req_i,
  input wire logic [7:0] dly_i,
  input wire logic search_start_i,
  output logic [15:0] dc_bus_v_o,
  output logic ctrl_supply_ok_o,
  output logic run_cmd_o,
  output logic search_done_o
);
  logic [8:0] cnt_r = 9'h000;
  // DC bus sits at 195 V when fed, 80 V when lost
  assign dc_bus_v_o = pwr_i ? 16'h00C3 : 16'h0050;
  assign ctrl_supply_ok_o = sup_i;
  assign run_cmd_o = run_req_i; // Run held through the interruption
  initial search_done_o = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Search answers dly_i + 1 cycles after the request, for one cycle
  always @(posedge clk_i) begin
    search_done_o <= (cnt_r == 9'h001);
    if (search_start_i) begin
      cnt_r <= {1'b0, dly_i} + 9'h001;
    end else if (cnt_r != 9'h000) begin
      cnt_r <= cnt_r - 9'h001;
    end
  end
endmodule

// ---- test/ridethrough_ctrl_tb_top.sv ----
// Self-checking bench of the ride-through supervisor.
// Assumes short tick and loss counts: 512 cycles per tenth, 40 cycles per 15 ms.
`timescale 1ns/10ps
`include "plr_consts.svh"
module ridethrough_ctrl_tb_top;
  localparam int unsigned TK = 512;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic err_i = 1'b0;
  logic pwr = 1'b1;
  logic sup = 1'b1;
  logic run_req = 1'b0;
  logic [7:0] dly = 8'h00;
  logic [31:0] dat_o;
  logic ack_o, run_cmd, sup_ok, search_done, running_o, block_o, recovering_o;
  logic uv_fault_o, err_o, search_start_o;
  logic [1:0] search_method_o;
  logic [7:0] volt_level_o;
  logic [15:0] dc_bus_v;
  int errors = 0;
  int cmp_count = 0;
  int srch_n = 0;
  logic [31:0] q;
  int n;
  int s;

  ridethrough_ctrl #(.TICK_CYC(TK), .LOSS_CYC(40), .HV_CLASS(1'b0)) ridethrough_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .run_cmd_i(run_cmd),
    .ctrl_supply_ok_i(sup_ok), .dc_bus_v_i(dc_bus_v), .err_i(err_i), .search_done_i(search_done),
    .running_o(running_o), .block_o(block_o), .recovering_o(recovering_o), .uv_fault_o(uv_fault_o),
    .err_o(err_o), .search_start_o(search_start_o), .search_method_o(search_method_o),
    .volt_level_o(volt_level_o));
  plr_partner plr_partner_inst (
    .clk_i(clk_i), .pwr_i(pwr), .sup_i(sup), .run_req_i(run_req), .dly_i(dly),
    .search_start_i(search_start_o), .dc_bus_v_o(dc_bus_v), .ctrl_supply_ok_o(sup_ok),
    .run_cmd_o(run_cmd), .search_done_o(search_done));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (search_start_o === 1'b1) srch_n <= srch_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout();
    errors++;
    $display("[FAIL] %0t wait limit got %0h exp %0h", $time, 0, 1);
    close_out();
  endtask
  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hF;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) timeout();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return running_o;
      1: return uv_fault_o;
      2: return search_start_o;
      default: return volt_level_o === 8'h00;
    endcase
  endfunction
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    while (sig(k) !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > lim) timeout();
    end
  endtask
  task automatic clear_fault();
    run_req <= 1'b0;
    repeat (5) @(posedge clk_i);
    bus(1'b1, `PLR_IDX_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk1(uv_fault_o, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [13:0] ix [6] = '{`PLR_IDX_MODE, `PLR_IDX_RT, `PLR_IDX_MB, `PLR_IDX_VR, `PLR_IDX_UVL, `PLR_IDX_SS};
    logic [31:0] ev [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'hBE, 32'h2};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ix[i], 32'h0);
      chkw(q, ev[i]);
    end
    chk1(block_o, 1'b1);
    chkw(volt_level_o, 32'hFF);
    bus(1'b0, 14'h0100, 32'h0);
    chkw(q, 32'h0);
    bus(1'b0, `PLR_IDX_STAT, 32'h0);
    chkw(q, 32'h0000_0040);
    bus(1'b1, `PLR_IDX_SS, 32'h3);
    repeat (2) @(posedge clk_i);
    chkw(search_method_o, 32'h3);
  endtask
  task automatic t_mode0();
    bus(1'b1, `PLR_IDX_MODE, 32'h0);
    run_req <= 1'b1;
    wait_hi(0, 20);
    err_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk1(err_o, 1'b1);
    err_i <= 1'b0;
    pwr <= 1'b0;
    repeat (20) @(posedge clk_i);
    pwr <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk1(running_o, 1'b1);
    chk1(uv_fault_o, 1'b0);
    bus(1'b1, `PLR_IDX_UVL, 32'hC8);
    repeat (20) @(posedge clk_i);
    chk1(running_o, 1'b1);
    pwr <= 1'b0;
    wait_hi(1, 100);
    chk1(n >= 40 && n <= 48, 1'b1);
    pwr <= 1'b1;
    clear_fault();
    // Level 200 V is now active, so the 195 V bus holds the drive stopped
    run_req <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk1(running_o, 1'b0);
    chk1(uv_fault_o, 1'b0);
    bus(1'b1, `PLR_IDX_UVL, 32'hBE);
    wait_hi(0, 20);
    chk1(block_o, 1'b0);
    clear_fault();
  endtask
  task automatic t_mode1();
    bus(1'b1, `PLR_IDX_MODE, 32'h1);
    bus(1'b1, `PLR_IDX_RT, 32'h4);
    bus(1'b1, `PLR_IDX_VR, 32'h2);
    dly <= 8'h00;
    run_req <= 1'b1;
    wait_hi(0, 20);
    err_i <= 1'b1;
    pwr <= 1'b0;
    repeat (300) @(posedge clk_i);
    pwr <= 1'b1;
    chk1(err_o, 1'b0);
    chk1(block_o, 1'b1);
    wait_hi(2, 1200);
    chk1(n >= 2 * TK && n <= 2 * TK + 16, 1'b1);
    wait_hi(3, 20);
    wait_hi(0, 1200);
    chk1(n >= 2 * TK - 12 && n <= 2 * TK + 16, 1'b1);
    chkw(volt_level_o, 32'hFF);
    chk1(block_o, 1'b0);
    repeat (2) @(posedge clk_i);
    chk1(err_o, 1'b1);
    err_i <= 1'b0;
    s = srch_n;
    pwr <= 1'b0;
    wait_hi(1, 3000);
    chk1(n >= 4 * TK && n <= 4 * TK + 16, 1'b1);
    pwr <= 1'b1;
    repeat (50) @(posedge clk_i);
    chk1(running_o, 1'b0);
    chk1(srch_n == s, 1'b1);
    clear_fault();
  endtask
  task automatic t_mode2();
    bus(1'b1, `PLR_IDX_MODE, 32'h2);
    dly <= 8'h32;
    run_req <= 1'b1;
    wait_hi(0, 20);
    s = srch_n;
    pwr <= 1'b0;
    repeat (3000) @(posedge clk_i);
    pwr <= 1'b1;
    wait_hi(0, 4000);
    chk1(uv_fault_o, 1'b0);
    chk1(srch_n == s + 1, 1'b1);
    pwr <= 1'b0;
    sup <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk1(recovering_o, 1'b0);
    chk1(uv_fault_o, 1'b0);
    run_req <= 1'b0;
    pwr <= 1'b1;
    sup <= 1'b1;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_mode0();
    t_mode1();
    t_mode2();
    close_out();
  end
endmodule
